// ==== pkg/sdp_pkg.sv ====
// shared constants, codes and state types of the dram pin decode link
// Contract
// - active takes row, read/write takes column
// - mode set loads op-code from address inputs
// - read/write auto-precharge select high closes bank
// - precharge select low one bank, high all
// - burst-chop select low chops, high full burst
// - reset active low asynchronous, held high normally
// - read strobe edge-aligned, write strobe centred
// - lower strobe lower lane, upper strobe upper; controller read capture takes both lanes on the lower strobe
// - strobes always differential true/complement pairs
// - eight-bit enabled: termination strobe mirrors data strobe
// - enable bit zero: pin is mask; x4/x16 zero
// - inputs sampled at true clock rising crossing
// - chip select high ignores command; part of code
// - bank select picks bank or mode register
package sdp_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int BANKS  = 8;
  localparam int DQ_W   = 16;
  localparam int LANES  = 2;
  localparam int COL_W  = 10;
  localparam int MR_CNT = 4;
  // command code {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hf;
  // address bit roles
  localparam int AP_BIT   = 10;
  localparam int BC_BIT   = 12;
  localparam int TERMINATION_STROBE_BIT = 11;
  localparam int RTT_B0   = 2;
  localparam int RTT_B1   = 6;
  localparam int RTT_B2   = 9;
  localparam logic [1:0] MR_ONE = 2'h1;
  // link timing in link clock cycles; LINK_HALF counts system clock cycles
  localparam logic [4:0] READ_LAT   = 5'h02;
  localparam logic [4:0] WRITE_LAT  = 5'h02;
  localparam logic [4:0] BURST_FULL = 5'h08;
  localparam logic [4:0] BURST_CHOP = 5'h04;
  localparam logic [3:0] LINK_HALF  = 4'h2;
  // controller register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  // register fields
  localparam int CTRL_RST_BIT = 0;
  localparam int CTRL_ODT_BIT = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
  localparam int CMDF_BANK = 0;
  localparam int CMDF_AP   = 3;
  localparam int CMDF_BC   = 4;
  localparam int CMDF_KIND = 5;
  localparam int WD_MASK   = 16;
  localparam int ST_BEATS  = 4;
  // command kinds in the command register
  localparam logic [2:0] KIND_MRS = 3'h0;
  localparam logic [2:0] KIND_ACT = 3'h1;
  localparam logic [2:0] KIND_RD  = 3'h2;
  localparam logic [2:0] KIND_WR  = 3'h3;
  localparam logic [2:0] KIND_PRE = 3'h4;
  localparam logic [2:0] KIND_REF = 3'h5;
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'b001,
    DEV_READ  = 3'b010,
    DEV_WRITE = 3'b100
  } sdp_dev_state_t;
  typedef enum logic [2:0] {
    CTL_IDLE  = 3'b001,
    CTL_ISSUE = 3'b010,
    CTL_RUN   = 3'b100
  } sdp_ctl_state_t;
endpackage

// ==== pkg/sdp_link_if.sv ====
// pin-level link between memory controller and dram device
`timescale 1ns/100ps
interface sdp_link_if;
  logic        linkClk;
  logic        linkClkN;
  logic        resetN;
  logic        csN;
  logic        rasN;
  logic        casN;
  logic        weN;
  logic [13:0] addr;
  logic [2:0]  bank;
  logic        on_die_termination_enable;
  logic [1:0]  maskPin;
  logic [15:0] dqCtl;
  logic [1:0]  dqCtlOe;
  logic [15:0] dqDev;
  logic [1:0]  dqDevOe;
  logic [1:0]  dqsCtl;
  logic [1:0]  dqsCtlN;
  logic [1:0]  dqsCtlOe;
  logic [1:0]  dqsDev;
  logic [1:0]  dqsDevN;
  logic [1:0]  dqsDevOe;
  logic        dqsTermOn;
  logic        tdqsTermOn;
  wire  [15:0] dq;
  wire  [1:0]  dqs;
  wire  [1:0]  dqsN;
  // resolve the shared lanes; undriven data reads 0, strobe pair parks low/high
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign dq[8*i +: 8] = dqDevOe[i] ? dqDev[8*i +: 8] :
                          dqCtlOe[i] ? dqCtl[8*i +: 8] : 8'h00;
    assign dqs[i]  = dqsDevOe[i] ? dqsDev[i] : dqsCtlOe[i] ? dqsCtl[i] : 1'b0;
    assign dqsN[i] = dqsDevOe[i] ? dqsDevN[i] : dqsCtlOe[i] ? dqsCtlN[i] : 1'b1;
  end
  modport ctl (
    output linkClk, linkClkN, resetN, csN, rasN, casN, weN, addr, bank, on_die_termination_enable,
    output maskPin, dqCtl, dqCtlOe, dqsCtl, dqsCtlN, dqsCtlOe,
    input  dq, dqs, dqsN, dqsTermOn, tdqsTermOn
  );
  modport dev (
    input  linkClk, linkClkN, resetN, csN, rasN, casN, weN, addr, bank, on_die_termination_enable,
    input  maskPin, dq, dqs, dqsN,
    output dqDev, dqDevOe, dqsDev, dqsDevN, dqsDevOe, dqsTermOn, tdqsTermOn
  );
endinterface

// ==== hdl/sdp_dev_end.sv ====
// dram device end: command decode, bank state, mode registers, data lanes
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sdp_dev_end #(
  parameter int ORG = 16
) (
  // link to the controller
  sdp_link_if.dev link,
  // decoded command report
  output logic        cmdValid,
  output logic [3:0]  cmdKind,
  output logic [2:0]  cmdBank,
  output logic [13:0] cmdRow,
  output logic [9:0]  cmdCol,
  output logic        cmdAutoPre,
  output logic        cmdChop,
  output logic        cmdAllBanks,
  output logic [7:0]  bankOpen,
  // mode register writes
  output logic        modeWrite,
  output logic [1:0]  modeIndex,
  output logic [13:0] modeOpcode,
  // write data out, read data in
  output logic        wrValid,
  output logic [15:0] wrData,
  output logic [1:0]  wrMask,
  output logic        rdActive,
  input  wire  [15:0] rdData
);

  sdp_pkg::sdp_dev_state_t state;
  sdp_pkg::sdp_dev_state_t next_state;

  logic [13:0] modeReg [0:3];
  logic [13:0] openRow [0:7];
  logic [4:0]  cnt;
  logic [4:0]  len;
  logic [2:0]  accBank;
  logic        accAp;
  logic [1:0]  strobe;

  // command code; chip select high leaves a code that matches nothing
  wire [3:0] cmdCode = {link.csN, link.rasN, link.casN, link.weN};
  wire isMrs = (cmdCode == sdp_pkg::CMD_MRS);
  wire isPre = (cmdCode == sdp_pkg::CMD_PRE);
  wire isAct = (cmdCode == sdp_pkg::CMD_ACT);
  wire isWr  = (cmdCode == sdp_pkg::CMD_WR);
  wire isRd  = (cmdCode == sdp_pkg::CMD_RD);
  wire isRef = (cmdCode == sdp_pkg::CMD_REF);
  wire isAny = isMrs | isPre | isAct | isWr | isRd | isRef;

  // qualifier bits carried on the address inputs
  wire apSel = link.addr[sdp_pkg::AP_BIT];
  wire bcSel = link.addr[sdp_pkg::BC_BIT];
  wire [4:0] reqLen = bcSel ? sdp_pkg::BURST_FULL : sdp_pkg::BURST_CHOP;

  // bank select also picks the mode register; upper code points are dropped
  wire [1:0] mrSel   = link.bank[1:0];
  wire       mrValid = ~link.bank[2];

  // new accesses only start from idle; overlapping ones are dropped
  wire idle    = (state == sdp_pkg::DEV_IDLE);
  wire startRd = idle & isRd;
  wire startWr = idle & isWr;

  // beat window relative to the command edge
  wire [4:0] lat    = (state == sdp_pkg::DEV_READ) ? sdp_pkg::READ_LAT
                                                   : sdp_pkg::WRITE_LAT;
  wire [4:0] endCnt = 5'(lat + len);
  wire       inBeat = (cnt >= lat) && (cnt < endCnt);
  wire       atEnd  = ~idle && (cnt == endCnt);
  wire       apDone = atEnd & accAp;

  // termination strobe and mask selection from mode register one
  wire [13:0] mrOne    = modeReg[sdp_pkg::MR_ONE];
  wire        tdqsEn   = (ORG == 8) && mrOne[sdp_pkg::TERMINATION_STROBE_BIT];
  wire        odtAllow = mrOne[sdp_pkg::RTT_B0] | mrOne[sdp_pkg::RTT_B1] |
                         mrOne[sdp_pkg::RTT_B2];

  // state sequencing; a bare state flop keeps the sequence readable
  always_comb begin
    next_state = state;
    case (state)
      sdp_pkg::DEV_IDLE: begin
        if (startRd) begin
          next_state = sdp_pkg::DEV_READ;
        end else if (startWr) begin
          next_state = sdp_pkg::DEV_WRITE;
        end
      end
      sdp_pkg::DEV_READ,
      sdp_pkg::DEV_WRITE: begin
        if (atEnd) begin
          next_state = sdp_pkg::DEV_IDLE;
        end
      end
      default: begin
        next_state = sdp_pkg::DEV_IDLE;
      end
    endcase
  end

  // everything samples on the rising true clock, complement falling
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      state <= sdp_pkg::DEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // access context: edge counter, burst length, target bank
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      cnt     <= 5'h00;
      len     <= 5'h00;
      accBank <= 3'h0;
      accAp   <= 1'b0;
    end else if (startRd | startWr) begin
      cnt     <= 5'h01;
      len     <= reqLen;
      accBank <= link.bank;
      accAp   <= apSel;
    end else if (!idle) begin
      cnt <= 5'(cnt + 5'h01);
    end
  end

  // command report toward the array side
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      cmdValid    <= 1'b0;
      cmdKind     <= sdp_pkg::CMD_DES;
      cmdBank     <= 3'h0;
      cmdAutoPre  <= 1'b0;
      cmdChop     <= 1'b0;
      cmdAllBanks <= 1'b0;
    end else begin
      cmdValid    <= isAny;
      cmdKind     <= cmdCode;
      cmdBank     <= link.bank;
      cmdAutoPre  <= (isRd | isWr) & apSel;
      cmdChop     <= (isRd | isWr) & ~bcSel;
      cmdAllBanks <= isPre & apSel;
    end
  end

  // row on active, latched row plus column on read or write
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      cmdRow <= 14'h0000;
      cmdCol <= 10'h000;
    end else if (isAct) begin
      cmdRow <= link.addr;
    end else if (isRd | isWr) begin
      cmdRow <= openRow[link.bank];
      cmdCol <= link.addr[9:0];
    end
  end

  // per-bank open flag and row; an active beats a same-edge auto-precharge
  for (genvar b = 0; b < 8; b++) begin : g_bank
    wire hitBank = (link.bank == 3'(b));
    wire preHit  = isPre & (apSel | hitBank);
    wire autoHit = apDone & (accBank == 3'(b));
    always_ff @(posedge link.linkClk or negedge link.resetN) begin
      if (!link.resetN) begin
        bankOpen[b] <= 1'b0;
        openRow[b]  <= 14'h0000;
      end else if (isAct & hitBank) begin
        bankOpen[b] <= 1'b1;
        openRow[b]  <= link.addr;
      end else if (preHit | autoHit) begin
        bankOpen[b] <= 1'b0;
      end
    end
  end

  // mode registers load the op-code from the address inputs
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      for (int m = 0; m < 4; m++) begin
        modeReg[m] <= 14'h0000;
      end
    end else if (isMrs & mrValid) begin
      modeReg[mrSel] <= link.addr;
    end
  end

  // mode write report
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      modeWrite  <= 1'b0;
      modeIndex  <= 2'h0;
      modeOpcode <= 14'h0000;
    end else begin
      modeWrite <= isMrs & mrValid;
      if (isMrs & mrValid) begin
        modeIndex  <= mrSel;
        modeOpcode <= link.addr;
      end
    end
  end

  // read lanes: data and strobe change at the same edge, so edges align
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      link.dqDev    <= 16'h0000;
      link.dqDevOe  <= 2'h0;
      link.dqsDevOe <= 2'h0;
      strobe        <= 2'h0;
      rdActive      <= 1'b0;
    end else if ((state == sdp_pkg::DEV_READ) && inBeat) begin
      link.dqDev    <= rdData;
      link.dqDevOe  <= 2'h3;
      link.dqsDevOe <= 2'h3;
      strobe        <= ~strobe;
      rdActive      <= 1'b1;
    end else begin
      link.dqDevOe  <= 2'h0;
      link.dqsDevOe <= 2'h0;
      strobe        <= 2'h0;
      rdActive      <= 1'b0;
    end
  end

  // bursts are even, so the strobe ends low and parks cleanly
  assign link.dqsDev  = strobe;
  assign link.dqsDevN = ~strobe;

  // write capture; the controller centres its strobe on this edge
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      wrValid <= 1'b0;
      wrData  <= 16'h0000;
      wrMask  <= 2'h0;
    end else begin
      wrValid <= (state == sdp_pkg::DEV_WRITE) && inBeat;
      if ((state == sdp_pkg::DEV_WRITE) && inBeat) begin
        wrData <= link.dq;
        wrMask <= tdqsEn ? 2'h0 : link.maskPin;
      end
    end
  end

  // termination follows the registered odt when mode register one allows it
  always_ff @(posedge link.linkClk or negedge link.resetN) begin
    if (!link.resetN) begin
      link.dqsTermOn  <= 1'b0;
      link.tdqsTermOn <= 1'b0;
    end else begin
      link.dqsTermOn  <= link.on_die_termination_enable & odtAllow;
      link.tdqsTermOn <= link.on_die_termination_enable & odtAllow & tdqsEn;
    end
  end

endmodule

// ==== hdl/sdp_ctl_end.sv ====
// controller end: apb registers, link clock divider, command and data sequencer
`timescale 1ns/100ps
module sdp_ctl_end #(
  parameter logic [3:0] LINK_HALF = sdp_pkg::LINK_HALF
) (
  // system clock and reset
  input  wire         clock,
  input  wire         rst,
  // apb slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire  [7:0]  paddr,
  input  wire  [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // link to the device
  sdp_link_if.ctl     link
);

  sdp_pkg::sdp_ctl_state_t state;
  logic [1:0]  ctrlReg;
  logic [13:0] addrReg;
  logic [15:0] wdataReg;
  logic [1:0]  wmaskReg;
  logic [2:0]  bankReg;
  logic        apReg;
  logic        bcReg;
  logic [2:0]  kindReg;
  logic [15:0] rdataReg;
  logic [4:0]  beats;
  logic [3:0]  div;
  logic [4:0]  falls;
  logic [2:0]  stSync;
  logic [15:0] dqS1;
  logic [15:0] dqS2;
  logic        pend;

  // apb decode; writes land only at the sampled access edge
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire selCtl = (paddr == sdp_pkg::REG_CTRL);
  wire selCmd = (paddr == sdp_pkg::REG_CMD);
  wire selAdr = (paddr == sdp_pkg::REG_ADDR);
  wire selWd  = (paddr == sdp_pkg::REG_WDATA);
  wire selSt  = (paddr == sdp_pkg::REG_STATUS);
  wire selRd  = (paddr == sdp_pkg::REG_RDATA);
  wire mapped = selCtl | selCmd | selAdr | selWd | selSt | selRd;
  wire busy   = (state != sdp_pkg::CTL_IDLE);
  wire refuse = ~mapped | (pwrite & selCmd & busy);
  wire go     = access & pwrite & selCmd & ~busy;
  wire [31:0] rdMux =
    selCtl ? {30'h0, ctrlReg} :
    selAdr ? {18'h0, addrReg} :
    selWd  ? {14'h0, wmaskReg, wdataReg} :
    selSt  ? {23'h0, beats, 3'h0, busy} :
    selRd  ? {16'h0, rdataReg} : 32'h0;

  // no wait state: ready is already high in the first access cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & refuse;
      prdata  <= setup ? rdMux : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlReg  <= sdp_pkg::CTRL_RESET_VAL;
      addrReg  <= 14'h0;
      wdataReg <= 16'h0;
      wmaskReg <= 2'h0;
      {kindReg, bcReg, apReg, bankReg} <= 8'h0;
    end else if (access & pwrite) begin
      if (selCtl) ctrlReg <= pwdata[1:0];
      if (selAdr) addrReg <= pwdata[13:0];
      if (selWd) {wmaskReg, wdataReg} <= pwdata[17:0];
      if (go) {kindReg, bcReg, apReg, bankReg} <= pwdata[7:0];
    end
  end

  // link clock from a divider; command, address, odt and data pins change at its falling edge
  wire halfDone = (div == 4'(LINK_HALF - 4'h1));
  wire riseTick = halfDone & ~link.linkClk;
  wire fallTick = halfDone & link.linkClk;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div           <= 4'h0;
      link.linkClk  <= 1'b0;
      link.linkClkN <= 1'b1;
    end else begin
      div           <= halfDone ? 4'h0 : 4'(div + 4'h1);
      link.linkClk  <= link.linkClk ^ halfDone;
      link.linkClkN <= ~(link.linkClk ^ halfDone);
    end
  end

  // command pins and qualifiers from the command register
  wire isRw   = (kindReg == sdp_pkg::KIND_RD) | (kindReg == sdp_pkg::KIND_WR);
  wire isPre  = (kindReg == sdp_pkg::KIND_PRE);
  wire [3:0] kindCode =
    (kindReg == sdp_pkg::KIND_MRS) ? sdp_pkg::CMD_MRS :
    (kindReg == sdp_pkg::KIND_ACT) ? sdp_pkg::CMD_ACT :
    (kindReg == sdp_pkg::KIND_RD)  ? sdp_pkg::CMD_RD  :
    (kindReg == sdp_pkg::KIND_WR)  ? sdp_pkg::CMD_WR  :
    isPre                          ? sdp_pkg::CMD_PRE :
    (kindReg == sdp_pkg::KIND_REF) ? sdp_pkg::CMD_REF : sdp_pkg::CMD_DES;
  wire apPin = (isRw | isPre) ? apReg : addrReg[sdp_pkg::AP_BIT];
  wire bcPin = isRw ? bcReg : addrReg[sdp_pkg::BC_BIT];
  wire [13:0] cmdAddr = {addrReg[13], bcPin, addrReg[11], apPin, addrReg[9:0]};
  wire [4:0]  len     = bcReg ? sdp_pkg::BURST_FULL : sdp_pkg::BURST_CHOP;
  wire [4:0]  wrEnd   = 5'(sdp_pkg::WRITE_LAT + len);
  wire isWrK  = (kindReg == sdp_pkg::KIND_WR);
  wire isRdK  = (kindReg == sdp_pkg::KIND_RD);
  wire wrWin  = isWrK && (falls >= sdp_pkg::WRITE_LAT) && (falls < wrEnd);
  wire done   = fallTick && (isWrK ? (falls == wrEnd) :
                             isRdK ? (beats == len) : (falls == 5'h01));

  // sequencer: issue at a falling edge, then deselect and move data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= sdp_pkg::CTL_IDLE;
      falls <= 5'h00;
      {link.csN, link.rasN, link.casN, link.weN} <= sdp_pkg::CMD_DES;
      link.addr <= 14'h0;
      link.bank <= 3'h0;
    end else begin
      case (state)
        sdp_pkg::CTL_IDLE: begin
          if (go) state <= sdp_pkg::CTL_ISSUE;
        end
        sdp_pkg::CTL_ISSUE: begin
          if (fallTick) begin
            {link.csN, link.rasN, link.casN, link.weN} <= kindCode;
            link.addr <= cmdAddr;
            link.bank <= bankReg;
            falls <= 5'h01;
            state <= sdp_pkg::CTL_RUN;
          end
        end
        sdp_pkg::CTL_RUN: begin
          if (fallTick) begin
            {link.csN, link.rasN, link.casN, link.weN} <= sdp_pkg::CMD_DES;
            falls <= 5'(falls + 5'h01);
          end
          if (done) state <= sdp_pkg::CTL_IDLE;
        end
        default: state <= sdp_pkg::CTL_IDLE;
      endcase
    end
  end

  // write lanes change at link fall, strobe toggles at link rise: centred
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.dqCtl    <= 16'h0;
      link.dqCtlOe  <= 2'h0;
      link.maskPin  <= 2'h0;
      link.dqsCtlOe <= 2'h0;
      link.dqsCtl   <= 2'h0;
      link.dqsCtlN  <= 2'h3;
    end else begin
      if (fallTick) begin
        link.dqCtl    <= wdataReg;
        link.maskPin  <= wrWin ? wmaskReg : 2'h0;
        link.dqCtlOe  <= {2{wrWin & (state == sdp_pkg::CTL_RUN)}};
        link.dqsCtlOe <= {2{wrWin & (state == sdp_pkg::CTL_RUN)}};
      end
      if (riseTick & link.dqsCtlOe[0]) begin
        link.dqsCtl  <= ~link.dqsCtl;
        link.dqsCtlN <= link.dqsCtl;
      end
    end
  end

  // read capture: strobe and data pass two flops; data taken a cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stSync   <= 3'h0;
      dqS1     <= 16'h0;
      dqS2     <= 16'h0;
      pend     <= 1'b0;
      beats    <= 5'h0;
      rdataReg <= 16'h0;
    end else begin
      stSync <= {stSync[1:0], link.dqs[0]};
      dqS1   <= link.dq;
      dqS2   <= dqS1;
      pend   <= stSync[1] ^ stSync[2];
      if (go) begin
        beats <= 5'h0;
      end else if (pend & isRdK & busy) begin
        beats <= 5'(beats + 5'h01);
        if (beats == 5'h0) rdataReg <= dqS2;
      end
    end
  end

  // device reset straight from software; odt changes with the other pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.resetN <= 1'b0;
      link.on_die_termination_enable    <= 1'b0;
    end else begin
      link.resetN <= ctrlReg[sdp_pkg::CTRL_RST_BIT];
      if (fallTick) link.on_die_termination_enable <= ctrlReg[sdp_pkg::CTRL_ODT_BIT];
    end
  end

endmodule

// ==== testbench/sdp_link_monitor.sv ====
// assertions on the pin link
`timescale 1ns/100ps
module sdp_link_monitor (
  // link clock and device reset
  input logic        linkClk,
  input logic        resetN,
  // command and address pins
  input logic        csN,
  input logic        rasN,
  input logic        casN,
  input logic        weN,
  input logic [13:0] addr,
  input logic        on_die_termination_enable,
  // strobes, lane enables and termination
  input logic [1:0]  dqDevOe,
  input logic [1:0]  dqsDevOe,
  input logic [1:0]  dqsDev,
  input logic [1:0]  dqsDevN,
  input logic [1:0]  dqsCtlOe,
  input logic [1:0]  dqsCtl,
  input logic [1:0]  dqsCtlN,
  input logic        dqsTermOn,
  input logic        tdqsTermOn
);
  // a read as registered at a rising link edge
  wire rdCmd = {csN, rasN, casN, weN} == sdp_pkg::CMD_RD;
  default clocking @(posedge linkClk); endclocking
  default disable iff (!resetN);
  AST_RD_FULL: assert property (
    rdCmd && addr[12] |-> ##3 dqDevOe[0] [*8] ##1 !dqDevOe[0])
    else $error("full read burst has wrong length");
  AST_RD_CHOP: assert property (
    rdCmd && !addr[12] |-> ##3 dqDevOe[0] [*4] ##1 !dqDevOe[0])
    else $error("chopped read burst has wrong length");
  AST_RD_CAUSE: assert property (
    $rose(dqDevOe[0]) |-> $past({csN, rasN, casN, weN}, 3) == sdp_pkg::CMD_RD)
    else $error("device drove data without a read");
  AST_DQS_FIRST: assert property ($rose(dqsDevOe[0]) |-> dqsDev[0])
    else $error("read strobe does not start high");
  AST_DQS_TOGGLE: assert property (
    dqsDevOe[0] && $past(dqsDevOe[0]) |-> dqsDev[0] != $past(dqsDev[0]))
    else $error("read strobe missed an edge");
  AST_LANES: assert property (dqsDevOe == dqDevOe && dqDevOe[1] == dqDevOe[0])
    else $error("strobe and byte lane enables differ");
  AST_DEV_DIFF: assert property (dqsDevOe[0] |-> dqsDevN[0] != dqsDev[0])
    else $error("device strobe pair not complementary");
  AST_CTL_DIFF: assert property (dqsCtlOe[1] |-> dqsCtlN[1] != dqsCtl[1])
    else $error("controller strobe pair not complementary");
  AST_TERM: assert property (dqsTermOn |-> $past(on_die_termination_enable))
    else $error("termination on without odt");
  AST_NO_TERMINATION_STROBE: assert property (!tdqsTermOn)
    else $error("termination strobe used on a sixteen-bit part");
  AST_RESET: assert property (
    disable iff (1'b0) !resetN |-> dqDevOe == 2'b00 && !dqsTermOn)
    else $error("device active while in reset");
  // main traffic seen at least once
  cover property (rdCmd && addr[12]);
  cover property (rdCmd && !addr[12]);
  cover property ($rose(dqsCtlOe[0]));
endmodule

// ==== testbench/tb.sv ====
// bench: two ends on the pin link, driven over apb
`timescale 1ns/100ps
`define CHK(g, w) begin cmpCount++; if ((g) !== (w)) begin errTotal++; \
  $display("[ERR] %0t got %h want %h", $time, g, w); end end
module tb;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, errFlag;
  logic [7:0]  paddr, bankOpen;
  logic [31:0] pwdata, prdata, rdWord;
  logic [15:0] rdData, wrData;
  logic        cmdValid, cmdAutoPre, cmdChop, cmdAllBanks, modeWrite, wrValid, rdActive;
  logic [3:0]  cmdKind;
  logic [2:0]  cmdBank, b;
  logic [13:0] cmdRow, modeOpcode, row, col;
  logic [9:0]  cmdCol;
  logic [1:0]  modeIndex, wrMask;
  logic [17:0] wdat;
  logic [33:0] ev;
  logic [4:0]  wrBeats;
  logic [33:0] evq[$];
  logic [15:0] modeQ[$];
  int          errTotal, cmpCount, cycles;
  sdp_link_if lnk ();
  sdp_ctl_end #(.LINK_HALF(sdp_pkg::LINK_HALF)) i_sdp_ctl_end (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.ctl));
  sdp_dev_end #(.ORG(16)) i_sdp_dev_end (.link(lnk.dev), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdBank(cmdBank), .cmdRow(cmdRow), .cmdCol(cmdCol),
    .cmdAutoPre(cmdAutoPre), .cmdChop(cmdChop), .cmdAllBanks(cmdAllBanks), .bankOpen(bankOpen),
    .modeWrite(modeWrite), .modeIndex(modeIndex), .modeOpcode(modeOpcode), .wrValid(wrValid),
    .wrData(wrData), .wrMask(wrMask), .rdActive(rdActive), .rdData(rdData));
  sdp_link_monitor i_sdp_link_monitor (.linkClk(lnk.linkClk), .resetN(lnk.resetN),
    .csN(lnk.csN), .rasN(lnk.rasN), .casN(lnk.casN), .weN(lnk.weN), .addr(lnk.addr),
    .on_die_termination_enable(lnk.on_die_termination_enable), .dqDevOe(lnk.dqDevOe), .dqsDevOe(lnk.dqsDevOe), .dqsDev(lnk.dqsDev),
    .dqsDevN(lnk.dqsDevN), .dqsCtlOe(lnk.dqsCtlOe), .dqsCtl(lnk.dqsCtl),
    .dqsCtlN(lnk.dqsCtlN), .dqsTermOn(lnk.dqsTermOn), .tdqsTermOn(lnk.tdqsTermOn));
  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // hang guard, well above what the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errTotal++;
      finish_test();
    end
  end
  // link domain: commands, mode loads, data beats
  always @(posedge lnk.linkClk) begin
    if (cmdValid === 1'b1) evq.push_back({cmdKind, cmdBank, cmdRow, cmdCol, cmdAutoPre,
                                          cmdChop, cmdAllBanks});
    if (modeWrite === 1'b1) modeQ.push_back({modeIndex, modeOpcode});
    if (rdActive === 1'b1) wrBeats++;
    if (wrValid === 1'b1) begin
      wrBeats++;
      `CHK({wrMask, wrData}, wdat)
    end
  end
  // beats a burst should carry for a given chop select
  function automatic logic [4:0] beats(input logic bc);
    return bc ? sdp_pkg::BURST_FULL : sdp_pkg::BURST_CHOP;
  endfunction
  // one apb transfer; an idle cycle keeps two calls apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdWord = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // issue one command, wait for idle, take its decoded report
  task automatic cmd(input logic [2:0] k, input logic ap, input logic bc, input logic [13:0] a);
    apb(1'b1, sdp_pkg::REG_ADDR, {18'h0, a});
    apb(1'b1, sdp_pkg::REG_CMD, {24'h0, k, bc, ap, b});
    rdWord = 32'h1;
    while (rdWord[0] !== 1'b0) apb(1'b0, sdp_pkg::REG_STATUS, 32'h0);
    wait (evq.size() > 0);
    ev = evq.pop_front();
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h94f9));
    {rst, psel, penable, pwrite, paddr, pwdata, rdData, wrBeats} = {4'h8, 8'h0, 53'h0};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, sdp_pkg::REG_CTRL, 32'h0);
    `CHK({rdWord[1:0], cmdKind}, {sdp_pkg::CTRL_RESET_VAL, 4'hf})
    apb(1'b0, 8'h18, 32'h0);
    `CHK({errFlag, rdWord}, {1'b1, 32'h0})
    apb(1'b1, sdp_pkg::REG_CTRL, 32'h3);
    repeat (12) @(posedge clock);
    b = 3'h1;
    row = 14'($urandom) & 14'h37ff | 14'h0004;
    cmd(sdp_pkg::KIND_MRS, 1'b0, 1'b1, row);
    wait (modeQ.size() > 0);
    `CHK(modeQ.pop_front(), {sdp_pkg::MR_ONE, row})
    repeat (8) @(posedge clock);
    `CHK({lnk.tdqsTermOn, lnk.dqsTermOn}, 2'b01)
    cmd(sdp_pkg::KIND_REF, 1'b0, 1'b1, row);
    `CHK(ev[33:30], sdp_pkg::CMD_REF)
    // every auto-precharge and burst-chop pairing on a random bank
    for (int i = 0; i < 4; i++) begin
      b = 3'($urandom);
      row = 14'($urandom);
      col = 14'($urandom);
      wdat = 18'($urandom);
      rdData <= 16'($urandom);
      apb(1'b1, sdp_pkg::REG_WDATA, {14'h0, wdat});
      cmd(sdp_pkg::KIND_ACT, 1'b0, 1'b1, row);
      `CHK({ev[33:13], bankOpen[b]}, {sdp_pkg::CMD_ACT, b, row, 1'b1})
      wrBeats = 5'h0;
      cmd(sdp_pkg::KIND_WR, 1'b0, i[1], col);
      `CHK(ev[33:1], {sdp_pkg::CMD_WR, b, row, col[9:0], 1'b0, ~i[1]})
      repeat (8) @(posedge clock);
      `CHK(wrBeats, beats(i[1]))
      wrBeats = 5'h0;
      cmd(sdp_pkg::KIND_RD, i[0], i[1], col);
      `CHK(ev[33:1], {sdp_pkg::CMD_RD, b, row, col[9:0], i[0], ~i[1]})
      `CHK({rdWord[8:4], wrBeats}, {2{beats(i[1])}})
      apb(1'b0, sdp_pkg::REG_RDATA, 32'h0);
      `CHK({rdWord[15:0], bankOpen[b]}, {rdData, ~i[0]})
      cmd(sdp_pkg::KIND_ACT, 1'b0, 1'b1, row);
      cmd(sdp_pkg::KIND_PRE, 1'b0, 1'b1, 14'h0);
      `CHK({ev[33:27], ev[0], bankOpen[b]}, {sdp_pkg::CMD_PRE, b, 2'b00})
      cmd(sdp_pkg::KIND_ACT, 1'b0, 1'b1, row);
      b = ~b;
      cmd(sdp_pkg::KIND_ACT, 1'b0, 1'b1, row);
      cmd(sdp_pkg::KIND_PRE, 1'b1, 1'b1, 14'h0);
      `CHK({ev[0], bankOpen}, {1'b1, 8'h00})
    end
    finish_test();
  end
endmodule
